// ==== logic/twi_flag_ctrl.sv ====
`timescale 1ns/100ps
// How it works
// - Byte done after eight bits plus ack.
// - General call flag in slave only.
// - Nack flag on received nack.
// - Master stop flag after bus free.
// - Slave stop flag only while addressed.
// - Start flag on issue or match.
// - Receive full set on load, read clears.
// - Master tbe on start or ack.
// - Slave tbe on move or read match.
// - Interrupt when any enabled flag set.
// - Debug run keeps clock in debug.
// - Source field selects four clock sources.
// - Divider applies to internal and high-speed.
// - Missing sources cannot be selected.
// - Address width bit picks seven/ten.
// - General call enable gates responses.
// - Baud divisor one to one-twenty-seven.
// - Writing one clears event flags.
// - Soft reset clears flags, self-clears.
// - Clear failure sets error, start in master only; drops request in any mode.
// - Channel enable gates operating clock.
module twi_flag_ctrl
   import twi_flag_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire bus_event_t event_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic debug_mode_in,
   input wire logic link_clock_in,
   output logic irq_out,
   output logic clock_run_out,
   output logic [1:0] clock_source_out,
   output logic [3:0] clock_div_out,
   output logic [6:0] baud_divisor_out,
   output logic ten_bit_addr_out,
   output logic gc_respond_out,
   output logic master_mode_out,
   output logic start_request_out,
   output logic soft_reset_out,
   output logic [7:0] tx_byte_out,
   output logic [7:0] tx_write_out
);

   function automatic logic [3:0] div_ratio(input logic [1:0] src,
                                            input logic [1:0] div);
      div_ratio = 4'h1;
      if (src == src_internal || src == src_high_speed) begin
         div_ratio = 4'h1 << div;
      end
   endfunction : div_ratio

   logic [15:0] clk_reg_ff, nxt_clk_reg;
   logic [15:0] mode_reg_ff, nxt_mode_reg;
   logic [15:0] ctl_reg_ff, nxt_ctl_reg;
   logic [6:0] baud_ff, nxt_baud;
   logic [7:0] flags_ff, nxt_flags;
   logic [7:0] enables_ff;
   logic [7:0] txd_ff;
   logic [7:0] rxd_ff;
   logic [2:0] sr_cnt_ff;
   sr_state_t sr_state_ff, nxt_sr_state;
   logic [31:0] rdata_ff;
   logic ready_ff;
   logic err_ff;
   logic irq_ff;
   logic run_ff;
   logic tx_wr_ff;
   logic [3:0] div_ff;
   logic lk_meta_ff, lk_sync_ff, lk_prev_ff;

   wire logic setup = psel_in && !penable_in;
   wire logic access = psel_in && penable_in && ready_ff;
   wire logic wr = access && pwrite_in;
   wire logic rd = access && !pwrite_in;
   wire logic hit_clk = paddr_in == clock_select_control_addr;
   wire logic hit_mod = paddr_in == address_mode_control_addr;
   wire logic hit_ctl = paddr_in == control_addr;
   wire logic hit_br = paddr_in == baud_addr;
   wire logic hit_fl = paddr_in == status_flag_register_addr;
   wire logic hit_en = paddr_in == enable_addr;
   wire logic hit_tx = paddr_in == transmit_data_register_addr;
   wire logic hit_rx = paddr_in == receive_data_register_addr;
   wire logic mapped = hit_clk | hit_mod | hit_ctl | hit_br | hit_fl |
                       hit_en | hit_tx | hit_rx;
   wire logic enabled = ctl_reg_ff[channel_enable_pos];
   wire logic master = ctl_reg_ff[master_mode_pos];
   wire logic sr_active = sr_state_ff != st_idle;
   wire logic [15:0] wdata16 = pwdata_in[15:0];
   wire logic [1:0] src_wr = wdata16[clock_source_lsb +: 2];
   wire logic src_ok = sources_present[src_wr];
   wire logic cfg_ok = !enabled;
   wire logic [7:0] clr_w1c = (wr && hit_fl) ?
                      flag_w1c_mask & wdata16[7:0] : 8'h00;
   wire logic rx_read = rd && hit_rx;
   wire logic tx_wr = wr && hit_tx;
   wire logic [7:0] nxt_enables = (wr && hit_en) ? wdata16[7:0] :
                                  enables_ff;
   wire logic gc_ok = event_in.gc_match && mode_reg_ff[general_call_en_pos];
   wire logic match = event_in.addr_match || gc_ok;
   wire logic link_edge = lk_sync_ff && !lk_prev_ff;

   // Event set terms per flag.
   logic [7:0] set_flag;
   assign set_flag[f_byte] = event_in.byte_done;
   assign set_flag[f_gc] = !master && gc_ok;
   assign set_flag[f_nack] = event_in.nack_seen;
   assign set_flag[f_stop] = event_in.stop_done &&
                             (master || event_in.addressed);
   assign set_flag[f_start] = (master && event_in.start_issued) ||
                              (!master && match) ||
                              (master && event_in.clear_fail);
   assign set_flag[f_err] = master && event_in.clear_fail;
   assign set_flag[f_rbf] = event_in.rx_loaded;
   assign set_flag[f_tbe] = master ?
      (event_in.start_issued || event_in.ack_seen) :
      (event_in.tx_moved || (match && event_in.read_bit));

   wire logic [7:0] clr_all = clr_w1c | {6'h00, rx_read, tx_wr} |
                              {8{sr_active}};

   always_comb begin
      nxt_flags = (flags_ff & ~clr_all) | (set_flag & {8{enabled}});
      if (sr_active) begin
         nxt_flags = 8'h00;
      end
   end

   always_comb begin
      nxt_clk_reg = clk_reg_ff;
      nxt_mode_reg = mode_reg_ff;
      nxt_baud = baud_ff;
      nxt_ctl_reg = ctl_reg_ff;
      if (wr && hit_clk && cfg_ok) begin
         nxt_clk_reg = wdata16 & clock_select_mask;
         if (!src_ok) begin
            nxt_clk_reg[clock_source_lsb +: 2] =
               clk_reg_ff[clock_source_lsb +: 2];
         end
      end
      if (wr && hit_mod && cfg_ok) begin
         nxt_mode_reg = wdata16 & address_mode_mask;
      end
      if (wr && hit_br && cfg_ok && wdata16[6:0] != 7'h00) begin
         nxt_baud = wdata16[6:0];
      end
      if (wr && hit_ctl) begin
         nxt_ctl_reg = (wdata16 & control_mask) |
                       (ctl_reg_ff & 16'h0002);
      end
      if (master && event_in.start_issued || event_in.clear_fail) begin
         nxt_ctl_reg[start_request_pos] = 1'b0;
      end
      if (sr_state_ff == st_done) begin
         nxt_ctl_reg[soft_reset_pos] = 1'b0;
      end
   end

   always_comb begin
      nxt_sr_state = sr_state_ff;
      case (sr_state_ff)
         st_idle: begin
            if (wr && hit_ctl && wdata16[soft_reset_pos]) begin
               nxt_sr_state = st_run;
            end
         end
         st_run: begin
            if (sr_cnt_ff == soft_reset_last) begin
               nxt_sr_state = st_done;
            end
         end
         st_done: nxt_sr_state = st_idle;
         default: nxt_sr_state = st_idle;
      endcase
   end

   logic [31:0] rsel;
   always_comb begin
      rsel = 32'h0;
      if (hit_clk) rsel[15:0] = clk_reg_ff;
      if (hit_mod) rsel[15:0] = mode_reg_ff;
      if (hit_ctl) rsel[15:0] = ctl_reg_ff |
                  {14'h0, sr_active, 1'b0};
      if (hit_br) rsel[6:0] = baud_ff;
      if (hit_fl) rsel[7:0] = flags_ff;
      if (hit_en) rsel[7:0] = enables_ff;
      if (hit_tx) rsel[7:0] = txd_ff;
      if (hit_rx) rsel[7:0] = rxd_ff;
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         clk_reg_ff <= 16'h0;
         mode_reg_ff <= 16'h0;
         ctl_reg_ff <= 16'h0;
         baud_ff <= baud_reset;
         flags_ff <= 8'h0;
         sr_state_ff <= st_idle;
      end else begin
         clk_reg_ff <= nxt_clk_reg;
         mode_reg_ff <= nxt_mode_reg;
         ctl_reg_ff <= nxt_ctl_reg;
         baud_ff <= nxt_baud;
         flags_ff <= nxt_flags;
         sr_state_ff <= nxt_sr_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sr_cnt_ff <= 3'h0;
         enables_ff <= 8'h0;
         txd_ff <= 8'h0;
         rxd_ff <= 8'h0;
      end else begin
         sr_cnt_ff <= (sr_state_ff == st_run) ? sr_cnt_ff + 3'h1 : 3'h0;
         enables_ff <= nxt_enables;
         if (tx_wr) txd_ff <= wdata16[7:0];
         if (event_in.rx_loaded) rxd_ff <= rx_byte_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         ready_ff <= setup;
         err_ff <= setup && !mapped;
         rdata_ff <= setup && !pwrite_in ? rsel : 32'h0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         lk_meta_ff <= 1'b1;
         lk_sync_ff <= 1'b1;
         lk_prev_ff <= 1'b1;
         irq_ff <= 1'b0;
         div_ff <= 4'h1;
         run_ff <= 1'b0;
         tx_wr_ff <= 1'b0;
      end else begin
         lk_meta_ff <= link_clock_in;
         lk_sync_ff <= lk_meta_ff;
         lk_prev_ff <= lk_sync_ff;
         irq_ff <= |(nxt_flags & nxt_enables);
         div_ff <= div_ratio(nxt_clk_reg[clock_source_lsb +: 2],
                             nxt_clk_reg[clock_divider_lsb +: 2]);
         run_ff <= nxt_ctl_reg[channel_enable_pos] &&
                   (!debug_mode_in || nxt_clk_reg[debug_run_pos]);
         tx_wr_ff <= tx_wr;
      end
   end

   assign prdata_out = rdata_ff;
   assign pready_out = ready_ff;
   assign pslverr_out = err_ff;
   assign irq_out = irq_ff;
   assign clock_run_out = run_ff;
   assign clock_source_out = clk_reg_ff[clock_source_lsb +: 2];
   assign clock_div_out = div_ff;
   assign baud_divisor_out = baud_ff;
   assign ten_bit_addr_out = mode_reg_ff[address_width_pos];
   assign gc_respond_out = mode_reg_ff[general_call_en_pos];
   assign master_mode_out = master;
   assign start_request_out = ctl_reg_ff[start_request_pos];
   assign soft_reset_out = ctl_reg_ff[soft_reset_pos];
   assign tx_byte_out = txd_ff;
   assign tx_write_out = {7'h00, tx_wr_ff};

   wire logic unused_ok = &{1'b0, pstrb_in, link_edge, pwdata_in[31:16]};

   irq_follows_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      irq_out == |(flags_ff & enables_ff))
      else $error("Interrupt does not match enabled flags.");
   gc_slave_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      master_mode_out && !sr_active |=> !$rose(flags_ff[f_gc]))
      else $error("General call flag set in master mode.");
   set_wins_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      enabled && !sr_active && event_in.nack_seen |=> flags_ff[f_nack])
      else $error("Nack event lost.");
   sr_clear_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      sr_active |=> flags_ff == 8'h00)
      else $error("Flags not cleared by soft reset.");
   sr_ends_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      $rose(sr_active) |-> ##[1:6] !sr_active)
      else $error("Soft reset did not finish.");
   cfg_lock_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      enabled && $past(enabled) |-> $stable(clk_reg_ff))
      else $error("Clock register changed while enabled.");
   reserved_zero_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_reg_ff & ~clock_select_mask) == 16'h0)
      else $error("Reserved clock bits set.");
   baud_legal_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      baud_ff != 7'h00)
      else $error("Baud divisor zero.");
   byte_set_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      enabled && !sr_active && event_in.byte_done |=> flags_ff[f_byte])
      else $error("Byte done event lost.");
   stop_slave_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      !master && !event_in.addressed && event_in.stop_done |=>
      !$rose(flags_ff[f_stop]))
      else $error("Stop flag set while not addressed.");
   rx_clear_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      rx_read && !event_in.rx_loaded |=> !flags_ff[f_rbf])
      else $error("Receive full flag not cleared by read.");
   tx_empty_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      master && enabled && !sr_active && event_in.ack_seen |=>
      flags_ff[f_tbe])
      else $error("Transmit empty flag missing after ack.");
   w1c_clear_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      clr_w1c[f_byte] && !event_in.byte_done |=> !flags_ff[f_byte])
      else $error("Byte done flag not cleared by write.");
   start_drop_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      event_in.clear_fail |=> !start_request_out)
      else $error("Start request kept after clear failure.");
   run_gate_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      !enabled |-> !clock_run_out)
      else $error("Clock runs while channel disabled.");
   debug_stop_a: assert property (
      @(posedge clk_in) disable iff (!reset_n_in)
      $past(debug_mode_in) && !clk_reg_ff[debug_run_pos] |-> !clock_run_out)
      else $error("Clock runs in debug without debug run.");
endmodule : twi_flag_ctrl

// ==== logic/twi_flag_pkg.sv ====
package twi_flag_pkg;
   localparam logic [11:0] clock_select_control_addr = 12'h000;
   localparam logic [11:0] address_mode_control_addr = 12'h004;
   localparam logic [11:0] control_addr = 12'h008;
   localparam logic [11:0] baud_addr = 12'h00c;
   localparam logic [11:0] status_flag_register_addr = 12'h010;
   localparam logic [11:0] enable_addr = 12'h014;
   localparam logic [11:0] transmit_data_register_addr = 12'h018;
   localparam logic [11:0] receive_data_register_addr = 12'h01c;
   localparam int debug_run_pos = 8;
   localparam int clock_divider_lsb = 4;
   localparam int clock_source_lsb = 0;
   localparam int address_width_pos = 2;
   localparam int general_call_en_pos = 1;
   localparam int channel_enable_pos = 0;
   localparam int soft_reset_pos = 1;
   localparam int start_request_pos = 2;
   localparam int master_mode_pos = 5;
   localparam logic [15:0] clock_select_mask = 16'h0133;
   localparam logic [15:0] address_mode_mask = 16'h0006;
   localparam logic [15:0] control_mask = 16'h0027;
   localparam logic [6:0] baud_reset = 7'h7f;
   localparam logic [1:0] src_internal = 2'h0;
   localparam logic [1:0] src_low_speed = 2'h1;
   localparam logic [1:0] src_high_speed = 2'h2;
   localparam logic [1:0] src_external = 2'h3;
   localparam logic [3:0] sources_present = 4'hf;
   localparam int soft_reset_cycles = 4;
   localparam logic [2:0] soft_reset_last = 3'h3;
   localparam logic [7:0] flag_w1c_mask = 8'hfc;
   // Flag bit positions in the status flag register.
   localparam int f_byte = 7;
   localparam int f_gc = 6;
   localparam int f_nack = 5;
   localparam int f_stop = 4;
   localparam int f_start = 3;
   localparam int f_err = 2;
   localparam int f_rbf = 1;
   localparam int f_tbe = 0;

   typedef struct packed {
      logic byte_done;
      logic ack_seen;
      logic nack_seen;
      logic stop_done;
      logic start_issued;
      logic addr_match;
      logic gc_match;
      logic read_bit;
      logic rx_loaded;
      logic tx_moved;
      logic clear_fail;
      logic addressed;
   } bus_event_t;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_run = 2'b01,
      st_done = 2'b10
   } sr_state_t;
endpackage : twi_flag_pkg

// ==== testbench/twi_bus_party.sv ====
`timescale 1ns/100ps
module twi_bus_party
   import twi_flag_pkg::*;
(
   input wire logic clk_in,
   output bus_event_t event_out,
   output logic [7:0] rx_byte_out,
   output logic link_clock_out
);
   logic frame_on = 1'b0;
   initial begin
      event_out = '0;
      rx_byte_out = 8'h00;
      link_clock_out = 1'b1;
   end
   // The bus clock idles high and toggles only inside a frame.
   always begin
      #40;
      link_clock_out = frame_on ? !link_clock_out : 1'b1;
   end
   // Presents one bus event for a single cycle inside a short frame.
   task automatic send(input bus_event_t ev, input logic [7:0] data);
      @(posedge clk_in);
      frame_on <= 1'b1;
      event_out <= ev;
      rx_byte_out <= data;
      @(posedge clk_in);
      event_out <= '0;
      rx_byte_out <= ~data;
      repeat (16) @(posedge clk_in);
      frame_on <= 1'b0;
   endtask : send
endmodule : twi_bus_party

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
   import twi_flag_pkg::*;
   ;
   logic clk_in, reset_n_in = 1'b0, debug_mode = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, slverr, irq, clock_run, ten_bit, gc_resp;
   logic master_mode, start_req, soft_rst, link_clk;
   logic [1:0] clk_src;
   logic [3:0] clk_div;
   logic [6:0] baud;
   logic [7:0] tx_byte, rx_byte, tx_wr_pulse;
   bus_event_t ev;
   int err_count = 0;
   int n_compared = 0;
   int n_tx_wr = 0;
   // Each entry holds master mode, bus event and the expected flags.
   logic [20:0] tab [16] = '{
      21'h0_800_80, 21'h1_800_80, 21'h0_060_48,
      21'h1_020_00, 21'h0_200_20, 21'h1_200_20,
      21'h1_100_10, 21'h0_101_10, 21'h0_100_00,
      21'h1_080_09, 21'h1_400_01, 21'h0_050_09,
      21'h0_040_08, 21'h0_004_01, 21'h0_008_02,
      21'h1_002_0c
   };
   twi_flag_ctrl u_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .event_in(ev),
      .rx_byte_in(rx_byte), .debug_mode_in(debug_mode),
      .link_clock_in(link_clk), .irq_out(irq), .clock_run_out(clock_run),
      .clock_source_out(clk_src), .clock_div_out(clk_div),
      .baud_divisor_out(baud), .ten_bit_addr_out(ten_bit),
      .gc_respond_out(gc_resp), .master_mode_out(master_mode),
      .start_request_out(start_req), .soft_reset_out(soft_rst),
      .tx_byte_out(tx_byte), .tx_write_out(tx_wr_pulse)
   );
   twi_bus_party u_party (
      .clk_in(clk_in), .event_out(ev), .rx_byte_out(rx_byte),
      .link_clock_out(link_clk)
   );
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = !clk_in;
   end
   // Counts one-cycle pulses that announce a transmit data write.
   always @(posedge clk_in) begin
      if (tx_wr_pulse == 8'h01) begin
         n_tx_wr++;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   task automatic timed_out;
      err_count++;
      $display("ERROR %0t: wait timed out", $time);
      complete_run();
   endtask : timed_out
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         timed_out();
      end
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask : rd
   task automatic sreset(input logic m);
      int n;
      wr(control_addr, {26'h0, m, 5'h03});
      chk(32'(soft_rst), 32'h1);
      for (n = 0; n < 2 || (soft_rst !== 1'b0 && n < 40); n++) begin
         @(posedge clk_in);
      end
      if (n >= 40) begin
         timed_out();
      end
      rd(control_addr, {26'h0, m, 5'h01});
      rd(status_flag_register_addr, 32'h0);
      chk(32'(master_mode), 32'(m));
   endtask : sreset
   initial begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd(clock_select_control_addr, 32'h0);
      rd(address_mode_control_addr, 32'h0);
      chk(32'(baud), 32'h7f);
      for (int s = 0; s < 4; s++) begin
         wr(clock_select_control_addr, 32'hfff0 | 32'(s));
         rd(clock_select_control_addr, 32'h0130 | 32'(s));
         chk(32'(clk_src), 32'(s));
         chk(32'(clk_div), (s % 2) ? 32'h1 : 32'h8);
      end
      wr(address_mode_control_addr, 32'hffff);
      rd(address_mode_control_addr, 32'h6);
      chk({30'h0, ten_bit, gc_resp}, 32'h3);
      wr(address_mode_control_addr, 32'h2);
      chk({30'h0, ten_bit, gc_resp}, 32'h1);
      wr(baud_addr, 32'h0);
      chk(32'(baud), 32'h7f);
      wr(baud_addr, 32'h1);
      chk(32'(baud), 32'h1);
      wr(clock_select_control_addr, 32'h100);
      debug_mode <= 1'b1;
      wr(control_addr, 32'h1);
      rd(control_addr, 32'h1);
      chk(32'(clock_run), 32'h1);
      wr(control_addr, 32'h0);
      wr(clock_select_control_addr, 32'h0);
      chk(32'(clock_run), 32'h0);
      wr(control_addr, 32'h1);
      wr(clock_select_control_addr, 32'h133);
      rd(clock_select_control_addr, 32'h0);
      chk(32'(clock_run), 32'h0);
      debug_mode <= 1'b0;
      rd(control_addr, 32'h1);
      chk(32'(clock_run), 32'h1);
      wr(enable_addr, 32'hff);
      for (int i = 0; i < 16; i++) begin
         sreset(tab[i][20]);
         u_party.send(tab[i][19:8], 8'ha5);
         rd(status_flag_register_addr, {24'h0, tab[i][7:0]});
         chk(32'(irq), 32'(|tab[i][7:0]));
      end
      sreset(1'b0);
      u_party.send(12'h800, 8'h00);
      wr(enable_addr, 32'h7f);
      rd(enable_addr, 32'h7f);
      chk(32'(irq), 32'h0);
      wr(enable_addr, 32'h80);
      rd(status_flag_register_addr, 32'h80);
      chk(32'(irq), 32'h1);
      wr(status_flag_register_addr, 32'h0);
      rd(status_flag_register_addr, 32'h80);
      fork
         wr(status_flag_register_addr, 32'h80);
         begin
            @(posedge clk_in);
            u_party.send(12'h800, 8'h00);
         end
      join
      rd(status_flag_register_addr, 32'h80);
      wr(status_flag_register_addr, 32'hff);
      rd(status_flag_register_addr, 32'h0);
      chk(32'(irq), 32'h0);
      u_party.send(12'h008, 8'h5a);
      rd(status_flag_register_addr, 32'h2);
      rd(receive_data_register_addr, 32'h5a);
      rd(status_flag_register_addr, 32'h0);
      sreset(1'b1);
      u_party.send(12'h080, 8'h00);
      wr(transmit_data_register_addr, 32'h3c);
      rd(status_flag_register_addr, 32'h8);
      chk(32'(tx_byte), 32'h3c);
      chk(32'(n_tx_wr), 32'h1);
      wr(control_addr, 32'h25);
      chk(32'(start_req), 32'h1);
      u_party.send(12'h002, 8'h00);
      rd(status_flag_register_addr, 32'hc);
      chk(32'(start_req), 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(rdata, 32'h0);
      chk(32'(slverr), 32'h1);
      complete_run();
   end
endmodule : tb_top
